// ### hdl/ssis_pkg.sv
package ssis_pkg;

    // ==========================================================================
    // Field encodings
    // ==========================================================================

    // Tacho edge select codes; zero keeps the stage out of speed sensor mode.
    localparam logic [1:0] TES_NONE = 2'h0;
    localparam logic [1:0] TES_RISE = 2'h1;
    localparam logic [1:0] TES_FALL = 2'h2;
    localparam logic [1:0] TES_BOTH = 2'h3;

    // Input select codes; the last one means encoder or all pins released.
    localparam logic [1:0] IS_PIN_A = 2'h0;
    localparam logic [1:0] IS_PIN_B = 2'h1;
    localparam logic [1:0] IS_PIN_C = 2'h2;
    localparam logic [1:0] IS_ENC = 2'h3;

    // Pin indices inside the three-bit sensor pin vector.
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;
    localparam int PIN_C = 2;

    // ==========================================================================
    // Reset values
    // ==========================================================================

    // Active and pending input select after reset.
    localparam logic [1:0] IS_RESET = 2'h0;
    // Direction flag after reset.
    localparam logic DIR_RESET = 1'b0;

    // ==========================================================================
    // Types
    // ==========================================================================

    // Role that a sensor pin plays in the current configuration.
    typedef enum logic [1:0] {
        ROLE_GPIO = 2'b00,
        ROLE_ANALOG = 2'b01,
        ROLE_DIGITAL = 2'b10,
        ROLE_OFF = 2'b11
    } ssis_role_e;

    // Static mode bits written by software.
    typedef struct packed {
        logic pin_release_bit;
        logic sensor_flag;
        logic off_state_discharge_bit;
        logic [1:0] tacho_edge_select;
    } ssis_cfg_s;

endpackage

// ### hdl/ssis_top.sv
// What this block does
// - Non-zero edge select enters speed sensor mode.
// - Input select 11 encoder, else tachogenerator.
// - Tacho mux: 00 A, 01 B, 10 C.
// - Tacho events: rising, falling or both edges.
// - Unselected tacho pins stay general-purpose I/O.
// - Input select preloaded; direct access applies immediately.
// - Encoder event on every edge of both inputs.
// - Direction flag read-only, never steers counting.
// - Direction samples pin A on B falling edge.
// - Single encoder input still yields half-rate events.
// - Release, speed, select 11: A and B digital, C I/O, comparator off.
// - Sensorless: selected pin analog, others off-state unless released; 11 all I/O.
// - Position sensor: selected analog; 11 all I/O.
// - Release speed mode: comparator off, digital inputs.
// - Analog pins read zero on port data.
// - Digital sensor pins stay readable as port data.
module ssis_top (
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Static mode bits from software.
    input wire ssis_pkg::ssis_cfg_s cfg,
    // Value that software writes into the input select field.
    input wire logic [1:0] input_select_wr,
    // One-cycle write strobe for input_select_wr.
    input wire logic input_select_wr_en,
    // Direct access bit: a write takes effect at once.
    input wire logic direct_access_bit,
    // One-cycle commutation event from the delay manager.
    input wire logic commutation_event,
    // Raw levels of the three sensor pins, asynchronous.
    input wire logic [2:0] sensor_pins,
    // Active input select field.
    output logic [1:0] input_select,
    // One-cycle capture clock event.
    output logic capture_event,
    // Encoder direction, read-only status.
    output logic encoder_direction_flag,
    // Stage is in speed sensor mode.
    output logic speed_mode,
    // Phase comparator enable.
    output logic phase_comparator_en,
    // Role of each sensor pin.
    output ssis_pkg::ssis_role_e [2:0] pin_role,
    // Port data seen by the general-purpose I/O readers.
    output logic [2:0] gpio_data,
    // High where an off-state pin is driven low.
    output logic [2:0] pin_gnd_oe
);

    // ==========================================================================
    // Pin synchroniser
    // ==========================================================================

    // First stage; only the second stage reads it.
    logic [2:0] pin_meta;
    // Second stage, the first safe copy.
    logic [2:0] pin_sync;
    // Previous safe copy, for edge detection.
    logic [2:0] pin_prev;

    // Two flops bring the pins onto ref_clk, a third keeps history.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
            pin_prev <= 3'h0;
        end else begin
            pin_meta <= sensor_pins;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // Cycles of pin history since reset; saturates at all ones.
    logic [1:0] hist_cnt;

    // The history flops reset to zero, so a pin that idles high would look
    // like a rising edge just after reset. Edges are ignored until both
    // compared copies hold real pin samples.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            hist_cnt <= 2'h0;
        end else if (!(&hist_cnt)) begin
            hist_cnt <= hist_cnt + 2'h1;
        end
    end

    // High once the synchronised and previous copies are both valid.
    logic hist_ok;
    assign hist_ok = &hist_cnt;

    // Edge flags per pin on the synchronised copies.
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;
    assign pin_rise = {3{hist_ok}} & pin_sync & ~pin_prev;
    assign pin_fall = {3{hist_ok}} & ~pin_sync & pin_prev;

    // ==========================================================================
    // Input select preload
    // ==========================================================================

    // Value waiting for the next commutation.
    logic [1:0] is_pending;

    // The pending copy follows every write, so a later commutation
    // always commits the newest value.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            is_pending <= ssis_pkg::IS_RESET;
        end else if (input_select_wr_en) begin
            is_pending <= input_select_wr;
        end
    end

    // A direct write wins over a commit in the same cycle, because it
    // carries the newer value.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            input_select <= ssis_pkg::IS_RESET;
        end else if (input_select_wr_en && direct_access_bit) begin
            input_select <= input_select_wr;
        end else if (commutation_event) begin
            input_select <= is_pending;
        end
    end

    // ==========================================================================
    // Mode decode
    // ==========================================================================

    logic speed_now;
    logic enc_now;
    assign speed_now = cfg.tacho_edge_select != ssis_pkg::TES_NONE;
    assign enc_now = speed_now && (input_select == ssis_pkg::IS_ENC);

    // Comparator runs only for an analog pin outside speed mode; select 11
    // releases all pins and so switches it off as well.
    logic next_cmp;
    assign next_cmp = !speed_now && (input_select != ssis_pkg::IS_ENC);

    // Mode flags are registered so that every output comes from a flop.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            speed_mode <= 1'b0;
            phase_comparator_en <= 1'b0;
        end else begin
            speed_mode <= speed_now;
            phase_comparator_en <= next_cmp;
        end
    end

    // ==========================================================================
    // Capture events
    // ==========================================================================

    // Selected tacho pin edges; select 11 also indexes the mux, but its result is not used.
    logic sel_rise;
    logic sel_fall;
    assign sel_rise = pin_rise[input_select];
    assign sel_fall = pin_fall[input_select];

    // Tacho edge qualification by the edge select field.
    logic tacho_hit;
    always_comb begin
        case (cfg.tacho_edge_select)
            ssis_pkg::TES_RISE: tacho_hit = sel_rise;
            ssis_pkg::TES_FALL: tacho_hit = sel_fall;
            ssis_pkg::TES_BOTH: tacho_hit = sel_rise | sel_fall;
            default: tacho_hit = 1'b0;
        endcase
    end

    // Any edge of A or B counts in encoder mode, so one wired input
    // still gives half the rate. Edges on both pins in one cycle merge
    // into one pulse; real quadrature never does that.
    logic enc_hit;
    assign enc_hit = |(pin_rise[1:0] | pin_fall[1:0]);

    logic next_event;
    assign next_event = enc_now ? enc_hit : (speed_now && tacho_hit);

    // Registered event pulse, one cycle per qualifying edge.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            capture_event <= 1'b0;
        end else begin
            capture_event <= next_event;
        end
    end

    // ==========================================================================
    // Direction flag
    // ==========================================================================

    // Pin A is sampled on each falling edge of B. The flag is a status
    // output only and feeds no counter here.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            encoder_direction_flag <= ssis_pkg::DIR_RESET;
        end else if (enc_now && pin_fall[ssis_pkg::PIN_B]) begin
            encoder_direction_flag <= pin_sync[ssis_pkg::PIN_A];
        end
    end

    // ==========================================================================
    // Pin roles
    // ==========================================================================

    // Role of one pin from the mode bits.
    function automatic ssis_pkg::ssis_role_e role_of(input logic [1:0] idx);
        ssis_pkg::ssis_role_e r;
        r = ssis_pkg::ROLE_GPIO;
        if (speed_now) begin
            if (input_select == ssis_pkg::IS_ENC) begin
                r = (idx != 2'(ssis_pkg::PIN_C)) ? ssis_pkg::ROLE_DIGITAL : ssis_pkg::ROLE_GPIO;
            end else begin
                r = (idx == input_select) ? ssis_pkg::ROLE_DIGITAL : ssis_pkg::ROLE_GPIO;
            end
        end else if (input_select == ssis_pkg::IS_ENC) begin
            r = ssis_pkg::ROLE_GPIO;
        end else if (idx == input_select) begin
            r = ssis_pkg::ROLE_ANALOG;
        end else if (!cfg.pin_release_bit && !cfg.sensor_flag) begin
            r = ssis_pkg::ROLE_OFF;
        end
        return r;
    endfunction

    // One copy per pin: role, port data and grounding. Analog and off
    // pins read zero, because their digital path is shut.
    for (genvar i = 0; i < 3; i++) begin : g_pin
        ssis_pkg::ssis_role_e next_role;
        assign next_role = role_of(2'(i));

        always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
                pin_role[i] <= ssis_pkg::ROLE_GPIO;
                gpio_data[i] <= 1'b0;
                pin_gnd_oe[i] <= 1'b0;
            end else begin
                pin_role[i] <= next_role;
                gpio_data[i] <= pin_sync[i] && (next_role == ssis_pkg::ROLE_GPIO
                    || next_role == ssis_pkg::ROLE_DIGITAL);
                pin_gnd_oe[i] <= (next_role == ssis_pkg::ROLE_OFF) && cfg.off_state_discharge_bit;
            end
        end
    end

    // ==========================================================================
    // Assertions
    // ==========================================================================

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_idle_no_event: assert property (!speed_now |=> !capture_event)
        else $error("capture event outside speed mode");
    a_tacho_rise: assert property (speed_now && !enc_now && cfg.tacho_edge_select == ssis_pkg::TES_RISE
        |-> ##1 capture_event == $past(sel_rise))
        else $error("rising edge tacho event wrong");
    a_tacho_fall: assert property (speed_now && !enc_now && cfg.tacho_edge_select == ssis_pkg::TES_FALL
        |-> ##1 capture_event == $past(sel_fall))
        else $error("falling edge tacho event wrong");
    a_enc_every_edge: assert property (enc_now && enc_hit |=> capture_event)
        else $error("encoder edge lost");
    a_dir_sample: assert property (enc_now && pin_fall[1] |=> encoder_direction_flag == $past(pin_sync[0]))
        else $error("direction not sampled from pin A");
    a_dir_hold: assert property (!(enc_now && pin_fall[1]) |=> $stable(encoder_direction_flag))
        else $error("direction changed without B fall");
    a_is_preload: assert property (!(input_select_wr_en && direct_access_bit) && !commutation_event
        |=> $stable(input_select))
        else $error("input select changed without commit");
    a_is_direct: assert property (input_select_wr_en && direct_access_bit
        |=> input_select == $past(input_select_wr))
        else $error("direct write not applied");
    a_cmp_off_speed: assert property (speed_now ##1 speed_now |-> !phase_comparator_en)
        else $error("comparator on in speed mode");
    a_analog_masked: assert property (pin_role[0] == ssis_pkg::ROLE_ANALOG |-> !gpio_data[0])
        else $error("analog pin visible on port data");

    c_tacho_event: cover property (speed_now && !enc_now ##1 capture_event);
    c_enc_event: cover property (enc_now ##1 capture_event ##1 capture_event);
    c_dir_update: cover property (enc_now && pin_fall[1] && pin_sync[0]);
    c_commit: cover property (commutation_event && !input_select_wr_en && is_pending != input_select);

endmodule

// ### testbench/ssis_sensor_model.sv
// ==========================================================================
// Speed sensor model
// ==========================================================================
// Stands for a tachogenerator or a quadrature encoder on the three pins.
module ssis_sensor_model (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic enc_on,
    input wire logic reverse,
    input wire logic single,
    input wire logic [2:0] tacho_pins,
    output logic [2:0] sensor_pins
);
    timeunit 1ns;
    timeprecision 1ns;

    // Divider that spaces encoder steps four clocks apart.
    logic [1:0] cnt;
    // Quadrature phase; zero means both lines low.
    logic [1:0] phase;

    // One step every fourth clock keeps each edge apart from the next.
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !enc_on) begin
            cnt <= 2'h0;
        end else begin
            cnt <= cnt + 2'h1;
        end
    end

    // The phase walks forwards or backwards, so A leads or lags B.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            phase <= 2'h0;
        end else if (enc_on && cnt == 2'h3) begin
            phase <= reverse ? phase - 2'h1 : phase + 2'h1;
        end
    end

    // With one output missing, line B is left low rather than floating.
    assign sensor_pins = enc_on ? {tacho_pins[2], phase[1] & !single, phase[0] ^ phase[1]}
                                : tacho_pins;
endmodule

// ### testbench/tb_ssis_top.sv
// ==========================================================================
// Bench for the speed sensor input stage
// ==========================================================================
module tb_ssis_top;
    timeunit 1ns;
    timeprecision 1ns;

    // Stimulus and observed signals.
    logic ref_clk, sys_rst, is_wr_en, dac, comm, enc_on, rev, single;
    logic [1:0] is_wr, input_select;
    logic [2:0] tacho, pins, gpio_data, pin_gnd_oe;
    logic capture_event, encoder_direction_flag, speed_mode, phase_comparator_en;
    ssis_pkg::ssis_cfg_s cfg;
    ssis_pkg::ssis_role_e [2:0] pin_role;
    int bad_count, n_tests, ev_cnt;

    ssis_top i_ssis_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .cfg(cfg), .input_select_wr(is_wr),
        .input_select_wr_en(is_wr_en), .direct_access_bit(dac), .commutation_event(comm),
        .sensor_pins(pins), .input_select(input_select), .capture_event(capture_event),
        .encoder_direction_flag(encoder_direction_flag), .speed_mode(speed_mode),
        .phase_comparator_en(phase_comparator_en), .pin_role(pin_role), .gpio_data(gpio_data),
        .pin_gnd_oe(pin_gnd_oe));

    ssis_sensor_model i_ssis_sensor_model (.ref_clk(ref_clk), .sys_rst(sys_rst), .enc_on(enc_on),
        .reverse(rev), .single(single), .tacho_pins(tacho), .sensor_pins(pins));

    // 125 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Events are counted as they come, since each lasts one cycle only.
    always @(posedge ref_clk) begin
        if (capture_event === 1'b1) begin
            ev_cnt++;
        end
    end

    // Compares one value and reports a mismatch at once.
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Inputs change only at falling edges, away from the sampling edge.
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // Writes the input select field; three cycles let the roles settle.
    task automatic write_is(input logic [1:0] v, input logic d);
        is_wr = v;
        is_wr_en = 1'b1;
        dac = d;
        cyc(1);
        is_wr_en = 1'b0;
        dac = 1'b0;
        cyc(3);
    endtask

    // Pulses one tacho pin and compares the event count and its port data.
    task automatic pulse(input int pin, input int n_exp, input logic g_exp);
        ev_cnt = 0;
        tacho[pin] = 1'b1;
        cyc(6);
        check("gpio_data", 8'(gpio_data[pin]), 8'(g_exp));
        tacho[pin] = 1'b0;
        cyc(6);
        check("tacho events", 8'(ev_cnt), 8'(n_exp));
    endtask

    // Runs the encoder for sixteen steps, which ends with both lines low.
    task automatic run_enc(input logic r, input logic s, input int n_exp, input logic d_exp);
        ev_cnt = 0;
        rev = r;
        single = s;
        enc_on = 1'b1;
        cyc(64);
        enc_on = 1'b0;
        cyc(8);
        check("encoder events", 8'(ev_cnt), 8'(n_exp));
        check("direction", 8'(encoder_direction_flag), 8'(d_exp));
    endtask

    task automatic roles(input ssis_pkg::ssis_role_e c, input ssis_pkg::ssis_role_e b,
                         input ssis_pkg::ssis_role_e a, input logic comp);
        check("pin_role", 8'(pin_role), {2'h0, c, b, a});
        check("comparator", 8'(phase_comparator_en), 8'(comp));
    endtask

    // Main sequence.
    initial begin
        {sys_rst, is_wr_en, dac, comm, enc_on, rev, single} = 7'h40;
        {cfg, is_wr, tacho} = '0;
        {bad_count, n_tests, ev_cnt} = '0;
        cyc(3);
        sys_rst = 1'b0;
        cyc(4);
        check("input_select", 8'(input_select), 8'(ssis_pkg::IS_RESET));
        // A plain write waits for the commutation event.
        is_wr = ssis_pkg::IS_PIN_B;
        is_wr_en = 1'b1;
        cyc(1);
        is_wr_en = 1'b0;
        cyc(2);
        check("input_select", 8'(input_select), 8'(ssis_pkg::IS_PIN_A));
        comm = 1'b1;
        cyc(1);
        comm = 1'b0;
        cyc(1);
        check("input_select", 8'(input_select), 8'(ssis_pkg::IS_PIN_B));
        // Sensorless with discharge: A analog, B and C grounded.
        cfg.off_state_discharge_bit = 1'b1;
        write_is(ssis_pkg::IS_PIN_A, 1'b1);
        roles(ssis_pkg::ROLE_OFF, ssis_pkg::ROLE_OFF, ssis_pkg::ROLE_ANALOG, 1'b1);
        check("pin_gnd_oe", 8'(pin_gnd_oe), 8'h06);
        pulse(0, 0, 1'b0);
        // Position sensor with select 11 frees all pins.
        cfg.sensor_flag = 1'b1;
        write_is(ssis_pkg::IS_ENC, 1'b1);
        roles(ssis_pkg::ROLE_GPIO, ssis_pkg::ROLE_GPIO, ssis_pkg::ROLE_GPIO, 1'b0);
        // Released pins in encoder mode: A and B digital, C plain I/O.
        cfg.pin_release_bit = 1'b1;
        cfg.tacho_edge_select = ssis_pkg::TES_RISE;
        cyc(3);
        roles(ssis_pkg::ROLE_GPIO, ssis_pkg::ROLE_DIGITAL, ssis_pkg::ROLE_DIGITAL, 1'b0);
        check("speed_mode", 8'(speed_mode), 8'h01);
        // Reverse first, so a flag stuck at its reset value is caught.
        run_enc(1'b1, 1'b0, 16, 1'b1);
        run_enc(1'b0, 1'b0, 16, 1'b0);
        run_enc(1'b0, 1'b1, 8, 1'b0);
        pulse(2, 0, 1'b1);
        // Every edge code with every tacho pin; the next pin must stay quiet.
        for (int t = 1; t < 4; t++) begin
            for (int s = 0; s < 3; s++) begin
                cfg.tacho_edge_select = 2'(t);
                write_is(2'(s), 1'b1);
                pulse(s, (t == 3) ? 2 : 1, 1'b1);
                pulse((s + 1) % 3, 0, 1'b1);
            end
        end
        // Release with edge select 00: input select is left alone from here.
        write_is(ssis_pkg::IS_PIN_A, 1'b1);
        cfg.tacho_edge_select = ssis_pkg::TES_NONE;
        cyc(3);
        roles(ssis_pkg::ROLE_GPIO, ssis_pkg::ROLE_GPIO, ssis_pkg::ROLE_ANALOG, 1'b1);
        // Position sensor with pin A analog, then sensorless without discharge.
        cfg.pin_release_bit = 1'b0;
        cyc(3);
        roles(ssis_pkg::ROLE_GPIO, ssis_pkg::ROLE_GPIO, ssis_pkg::ROLE_ANALOG, 1'b1);
        cfg.sensor_flag = 1'b0;
        cfg.off_state_discharge_bit = 1'b0;
        cyc(3);
        roles(ssis_pkg::ROLE_OFF, ssis_pkg::ROLE_OFF, ssis_pkg::ROLE_ANALOG, 1'b1);
        check("pin_gnd_oe", 8'(pin_gnd_oe), 8'h00);
        pulse(1, 0, 1'b0);
        final_report();
    end
endmodule
